// File: core/hesb_consts.svh
`ifndef HESB_CONSTS_SVH
`define HESB_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets and reset values
// ----------------------------------------------------------------
`define HESB_ADDR_VOLT 8'h4A
`define HESB_ADDR_DIODE 8'h4B
`define HESB_ADDR_THR 8'h4C
`define HESB_RESET_VAL 8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define HESB_VOLT16_BIT 7
`define HESB_THR_LIMIT_BIT 7
`define HESB_THR_FULL_BIT 6
`define HESB_THR_ANY_BIT 0

// ----------------------------------------------------------------
// deep sleep masks (1 = masked in S3 and S4/5)
// ----------------------------------------------------------------
`define HESB_VOLT_FIXED_MASK 8'h47
`define HESB_VOLT_OPT_MASK 8'h38
`define HESB_DIODE_FIXED_MASK 8'h3C
`define HESB_THR_FIXED_MASK 8'hFF

// ----------------------------------------------------------------
// throttle measurement timing and band edges (256 samples)
// ----------------------------------------------------------------
`define HESB_CLK_PERIOD_NS 5
`define HESB_SAMPLE_NS 1000
`define HESB_SAMPLE_CYC (`HESB_SAMPLE_NS / `HESB_CLK_PERIOD_NS)
`define HESB_SAMPLES_LAST 8'hFF
`define HESB_EDGE_12P5 9'h020
`define HESB_EDGE_25 9'h040
`define HESB_EDGE_50 9'h080
`define HESB_EDGE_75 9'h0C0
`define HESB_EDGE_FULL 9'h100

`endif

// File: core/hesb_meter_if.sv
`timescale 1ns/1ps

interface hesb_meter_if;
    logic done;
    logic [8:0] hot_count;

    modport meter (output done, output hot_count);
    modport user (input done, input hot_count);
endinterface

// File: core/hesb_pkg.sv
package hesb_pkg;

    typedef enum logic [1:0] {
        HESB_S0,
        HESB_S1,
        HESB_S3,
        HESB_S45
    } hesb_sleep_type;

    typedef logic [7:0] hesb_byte_type;

endpackage

// File: core/hesb_throttle_meter.sv
`timescale 1ns/1ps
`include "hesb_consts.svh"

module hesb_throttle_meter #(
    parameter int SAMPLE_CYC = `HESB_SAMPLE_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cpu1_hot_input_b,
    hesb_meter_if.meter res
);

    // divider is 16 bits wide and needs at least two states
    if (SAMPLE_CYC < 2 || SAMPLE_CYC > 65536)
    begin : g_bad_sample_cyc
        $error("SAMPLE_CYC must lie in 2..65536");
    end

    logic [15:0] div_q, div_d;
    logic [7:0] smp_q, smp_d;
    logic [8:0] acc_q, acc_d;
    logic [8:0] cnt_q, cnt_d;
    logic done_q, done_d;
    logic tick;

    // ----------------------------------------------------------------
    // sample divider and hot-time accumulator
    // ----------------------------------------------------------------
    always_comb
    begin
        tick = (div_q == 16'(SAMPLE_CYC - 1));
        div_d = tick ? 16'h0000 : div_q + 16'h0001;
        smp_d = smp_q;
        acc_d = acc_q;
        cnt_d = cnt_q;
        done_d = 1'b0;
        if (tick)
        begin
            // fraction of a fixed interval with the hot input low
            if (smp_q == `HESB_SAMPLES_LAST)
            begin
                cnt_d = acc_q + {8'h00, ~cpu1_hot_input_b};
                acc_d = 9'h000;
                smp_d = 8'h00;
                done_d = 1'b1;
            end
            else
            begin
                acc_d = acc_q + {8'h00, ~cpu1_hot_input_b};
                smp_d = smp_q + 8'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            div_q <= 16'h0000;
            smp_q <= 8'h00;
            acc_q <= 9'h000;
            cnt_q <= 9'h000;
            done_q <= 1'b0;
        end
        else
        begin
            div_q <= div_d;
            smp_q <= smp_d;
            acc_q <= acc_d;
            cnt_q <= cnt_d;
            done_q <= done_d;
        end
    end

    assign res.done = done_q;
    assign res.hot_count = cnt_q;

endmodule // hesb_throttle_meter

// File: core/hesb_top.sv
// Operation
// - volt 9-16 out of window latch bits 0-7
// - volts 9,10,11,15 masked deep sleep; 12-14 optional
// - volt 16 flag never sleep masked
// - diode faults latch bits 0,1,6,7, mask optional
// - fuse inputs latch bits 2,3 in legacy mode
// - core voltage mismatch latches bits 4,5
// - any throttling above zero sets bit 0
// - bits 1-5 latch by throttle percentage band
// - full throttling sets bit 6
// - throttle over user limit sets bit 7
// - only limit flag feeds summary from throttle
// - write one clears, zero keeps
// - flags sticky; clear fails while condition persists
// - summary set while any counted flag set
// - sleep state and masks from input ports
`timescale 1ns/1ps
`include "hesb_consts.svh"

module hesb_top #(
    parameter int SAMPLE_CYC = `HESB_SAMPLE_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd_en,
    output logic [7:0] reg_rdata,
    input wire logic [1:0] sleep_state,
    input wire logic [2:0] volt_sleep_mask,
    input wire logic [3:0] diode_sleep_mask,
    input wire logic [7:0] volt_out_of_window,
    input wire logic [3:0] diode_fault,
    input wire logic fuse_input_eight,
    input wire logic fuse_input_nine,
    input wire logic legacy_vid_mode,
    input wire logic cpu1_vcore_mismatch,
    input wire logic cpu2_vcore_mismatch,
    input wire logic cpu1_hot_input_b,
    input wire logic [7:0] throttle_limit,
    output logic host_err_summary
);

    // ----------------------------------------------------------------
    // parameter check
    // ----------------------------------------------------------------
    if (SAMPLE_CYC < 2 || SAMPLE_CYC > 65536)
    begin : g_bad_sample_cyc
        $error("SAMPLE_CYC must lie in 2..65536");
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] hesb_w1c(
        input logic [7:0] q,
        input logic [7:0] evt,
        input logic hit,
        input logic [7:0] wdata
    );
        logic [7:0] clr;
        clr = hit ? wdata : 8'h00;
        hesb_w1c = (q & ~clr) | evt;
    endfunction

    function automatic logic hesb_hit(
        input logic [7:0] addr,
        input logic [7:0] offs
    );
        hesb_hit = (addr == offs);
    endfunction

    // ----------------------------------------------------------------
    // throttle meter
    // ----------------------------------------------------------------
    hesb_meter_if meter_bus ();

    hesb_throttle_meter #(
        .SAMPLE_CYC(SAMPLE_CYC)
    ) u_meter (
        .clk(clk),
        .rst_b(rst_b),
        .cpu1_hot_input_b(cpu1_hot_input_b),
        .res(meter_bus.meter)
    );

    // ----------------------------------------------------------------
    // throttle condition, held until the next measurement
    // ----------------------------------------------------------------
    logic [7:0] thr_cond_q, thr_cond_d;
    logic [8:0] hc;

    always_comb
    begin
        hc = meter_bus.hot_count;
        thr_cond_d = thr_cond_q;
        if (meter_bus.done)
        begin
            thr_cond_d[`HESB_THR_ANY_BIT] = (hc != 9'h000);
            thr_cond_d[1] = (hc < `HESB_EDGE_12P5);
            thr_cond_d[2] = (hc >= `HESB_EDGE_12P5) && (hc < `HESB_EDGE_25);
            thr_cond_d[3] = (hc >= `HESB_EDGE_25) && (hc < `HESB_EDGE_50);
            thr_cond_d[4] = (hc >= `HESB_EDGE_50) && (hc < `HESB_EDGE_75);
            thr_cond_d[5] = (hc >= `HESB_EDGE_75) && (hc < `HESB_EDGE_FULL);
            thr_cond_d[`HESB_THR_FULL_BIT] = (hc == `HESB_EDGE_FULL);
            thr_cond_d[`HESB_THR_LIMIT_BIT] =
                (hc > {1'b0, throttle_limit});
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            thr_cond_q <= `HESB_RESET_VAL;
        else
            thr_cond_q <= thr_cond_d;
    end

    // ----------------------------------------------------------------
    // event qualification by sleep state
    // ----------------------------------------------------------------
    hesb_pkg::hesb_sleep_type slp;
    logic deep;
    logic [7:0] volt_mask, diode_mask;
    logic [7:0] evt [3];
    logic [7:0] offs [3];

    always_comb
    begin
        slp = hesb_pkg::hesb_sleep_type'(sleep_state);
        deep = (slp == hesb_pkg::HESB_S3) || (slp == hesb_pkg::HESB_S45);
        volt_mask = `HESB_VOLT_FIXED_MASK |
            (`HESB_VOLT_OPT_MASK & {2'b00, volt_sleep_mask, 3'b000});
        volt_mask[`HESB_VOLT16_BIT] = 1'b0;
        diode_mask = `HESB_DIODE_FIXED_MASK | {diode_sleep_mask[3:2], 4'h0,
            diode_sleep_mask[1:0]};
        evt[0] = volt_out_of_window & ~(deep ? volt_mask : 8'h00);
        evt[1] = {diode_fault[3:2],
                  cpu2_vcore_mismatch, cpu1_vcore_mismatch,
                  fuse_input_nine & legacy_vid_mode,
                  fuse_input_eight & legacy_vid_mode,
                  diode_fault[1:0]} & ~(deep ? diode_mask : 8'h00);
        evt[2] = thr_cond_q & ~(deep ? `HESB_THR_FIXED_MASK : 8'h00);
        offs[0] = `HESB_ADDR_VOLT;
        offs[1] = `HESB_ADDR_DIODE;
        offs[2] = `HESB_ADDR_THR;
    end

    // ----------------------------------------------------------------
    // status registers, one per mapped offset
    // ----------------------------------------------------------------
    wire logic [7:0] stat_val [3];

    for (genvar g = 0; g < 3; g++)
    begin : g_stat
        logic [7:0] stat_q, stat_d;

        always_comb
        begin
            // set wins over a clear in the same cycle
            stat_d = hesb_w1c(stat_q, evt[g],
                reg_wr_en && hesb_hit(reg_addr, offs[g]), reg_wdata);
        end

        always_ff @(posedge clk or negedge rst_b)
        begin
            if (!rst_b)
                stat_q <= `HESB_RESET_VAL;
            else
                stat_q <= stat_d;
        end

        assign stat_val[g] = stat_q;
    end

    // ----------------------------------------------------------------
    // read data and summary
    // ----------------------------------------------------------------
    logic [7:0] rdata_q, rdata_d;
    logic summ_q, summ_d;

    always_comb
    begin
        rdata_d = rdata_q;
        if (reg_rd_en)
        begin
            rdata_d = 8'h00;
            for (int i = 0; i < 3; i++)
            begin
                if (hesb_hit(reg_addr, offs[i]))
                    rdata_d = stat_val[i];
            end
        end
        summ_d = (|stat_val[0]) || (|stat_val[1]) ||
            stat_val[2][`HESB_THR_LIMIT_BIT];
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rdata_q <= 8'h00;
            summ_q <= 1'b0;
        end
        else
        begin
            rdata_q <= rdata_d;
            summ_q <= summ_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign host_err_summary = summ_q;

endmodule // hesb_top

// File: verification/hesb_monitor.sv
`timescale 1ns/1ps
// ------------------------------------------------
// flag to summary and read-back checks
// ------------------------------------------------
module hesb_monitor (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_rdata,
    input wire logic [1:0] sleep_state,
    input wire logic [3:0] diode_sleep_mask,
    input wire logic [7:0] volt_out_of_window,
    input wire logic [3:0] diode_fault,
    input wire logic fuse_input_eight,
    input wire logic legacy_vid_mode,
    input wire logic cpu1_vcore_mismatch,
    input wire logic host_err_summary
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic awake;
    assign awake = !sleep_state[1];
    a_volt16_no_mask: assert property (
        volt_out_of_window[7] |-> ##2 host_err_summary)
        else $error("volt16 flag missing in summary");
    a_volt9_awake: assert property (
        volt_out_of_window[0] && awake |-> ##2 host_err_summary)
        else $error("volt9 flag missing in summary");
    a_diode_unmasked: assert property (
        diode_fault[0] && (awake || !diode_sleep_mask[0])
        |-> ##2 host_err_summary)
        else $error("diode flag missing in summary");
    a_fuse_legacy: assert property (
        fuse_input_eight && legacy_vid_mode && awake
        |-> ##2 host_err_summary)
        else $error("fuse flag missing in summary");
    a_vcore_flag: assert property (
        cpu1_vcore_mismatch && awake |-> ##2 host_err_summary)
        else $error("vcore flag missing in summary");
    a_volt_read_back: assert property (
        volt_out_of_window[7] ##1 (reg_rd_en && reg_addr == 8'h4A)
        |=> reg_rdata[7])
        else $error("volt16 flag not read back");
    a_diode_read_back: assert property (
        diode_fault[3] && (awake || !diode_sleep_mask[3])
        ##1 (reg_rd_en && reg_addr == 8'h4B) |=> reg_rdata[7])
        else $error("diode2a flag not read back");
    a_fuse_read_back: assert property (
        fuse_input_eight && legacy_vid_mode && awake
        ##1 (reg_rd_en && reg_addr == 8'h4B) |=> reg_rdata[2])
        else $error("fuse8 flag not read back");
    c_thr_read: cover property (reg_rd_en && reg_addr == 8'h4C);
    c_deep_volt: cover property (sleep_state == 2'h2 && volt_out_of_window[3]);
    c_summary: cover property (host_err_summary);
endmodule // hesb_monitor

// File: verification/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0, rst_b = 1'b0, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [7:0] volt_out_of_window = 8'h00, throttle_limit = 8'hFF;
    logic [1:0] sleep_state = 2'h0, hot_mode = 2'h1;
    logic [2:0] volt_sleep_mask = 3'h0;
    logic [3:0] diode_sleep_mask = 4'h0, diode_fault = 4'h0;
    logic fuse_input_eight = 1'b0, fuse_input_nine = 1'b0;
    logic cpu1_vcore_mismatch = 1'b0, cpu2_vcore_mismatch = 1'b0;
    logic legacy_vid_mode = 1'b1, cpu1_hot_input_b = 1'b1, host_err_summary;
    int err_total = 0, compares = 0;
    hesb_top #(.SAMPLE_CYC(3)) u_hesb_top (.clk, .rst_b, .reg_addr,
        .reg_wr_en, .reg_wdata, .reg_rd_en, .reg_rdata, .sleep_state,
        .volt_sleep_mask, .diode_sleep_mask, .volt_out_of_window,
        .diode_fault, .fuse_input_eight, .fuse_input_nine,
        .legacy_vid_mode, .cpu1_vcore_mismatch, .cpu2_vcore_mismatch,
        .cpu1_hot_input_b, .throttle_limit, .host_err_summary);
    initial
    begin
        forever #2.5 clk = ~clk;
    end
    // hot input: 0 low, 1 high, 2 toggles every cycle
    always @(negedge clk)
        cpu1_hot_input_b <= hot_mode[1] ? ~cpu1_hot_input_b : hot_mode[0];
    // ------------------------------------------------
    // access and compare tasks
    // ------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk8(input string n, input logic [7:0] e, g);
        compares++;
        if (g !== e)
        begin
            $display("BAD %s exp %h got %h", n, e, g);
            err_total++;
        end
    endtask
    task automatic chk1(input string n, input logic e, g);
        compares++;
        if (g !== e)
        begin
            $display("BAD %s exp %b got %b", n, e, g);
            err_total++;
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        cyc(1);
        reg_wr_en = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, e);
        reg_addr = a;
        reg_rd_en = 1'b1;
        cyc(1);
        reg_rd_en = 1'b0;
        chk8("rdata", e, reg_rdata);
        cyc(1);
    endtask
    task automatic ev(input logic [7:0] v, input logic [3:0] d, o);
        volt_out_of_window = v;
        diode_fault = d;
        {fuse_input_eight, fuse_input_nine} = o[3:2];
        {cpu1_vcore_mismatch, cpu2_vcore_mismatch} = o[1:0];
        cyc(1);
        volt_out_of_window = 8'h00;
        diode_fault = 4'h0;
        {fuse_input_eight, fuse_input_nine} = 2'h0;
        {cpu1_vcore_mismatch, cpu2_vcore_mismatch} = 2'h0;
    endtask
    task automatic thr(input logic [1:0] m, input logic [7:0] l);
        hot_mode = m;
        throttle_limit = l;
        cyc(1600);
        wr(8'h4C, 8'hFF);
    endtask
    task automatic finish_test;
        $display("err_total %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ------------------------------------------------
    // main sequence
    // ------------------------------------------------
    initial
    begin
        cyc(4);
        rst_b = 1'b1;
        rd(8'h4A, 8'h00);
        rd(8'h4B, 8'h00);
        rd(8'h4C, 8'h00);
        rd(8'h4D, 8'h00);
        ev(8'hFF, 4'h0, 4'h0);
        rd(8'h4A, 8'hFF);
        chk1("summary", 1'b1, host_err_summary);
        wr(8'h4A, 8'h0F);
        rd(8'h4A, 8'hF0);
        wr(8'h4A, 8'h00);
        rd(8'h4A, 8'hF0);
        volt_out_of_window = 8'h80;
        wr(8'h4A, 8'hFF);
        volt_out_of_window = 8'h00;
        rd(8'h4A, 8'h80);
        wr(8'h4A, 8'hFF);
        rd(8'h4A, 8'h00);
        sleep_state = 2'h2;
        volt_sleep_mask = 3'h5;
        ev(8'hFF, 4'h0, 4'h0);
        rd(8'h4A, 8'h90);
        sleep_state = 2'h3;
        volt_sleep_mask = 3'h0;
        ev(8'hFF, 4'h0, 4'h0);
        rd(8'h4A, 8'hB8);
        sleep_state = 2'h1;
        wr(8'h4A, 8'hFF);
        ev(8'h00, 4'hF, 4'hF);
        rd(8'h4B, 8'hFF);
        wr(8'h4B, 8'hFF);
        legacy_vid_mode = 1'b0;
        ev(8'h00, 4'h0, 4'hC);
        rd(8'h4B, 8'h00);
        legacy_vid_mode = 1'b1;
        sleep_state = 2'h2;
        diode_sleep_mask = 4'h5;
        ev(8'h00, 4'hF, 4'hF);
        rd(8'h4B, 8'h82);
        sleep_state = 2'h0;
        wr(8'h4B, 8'hFF);
        thr(2'h1, 8'hFF);
        rd(8'h4C, 8'h02);
        cyc(2);
        chk1("summary", 1'b0, host_err_summary);
        thr(2'h2, 8'h7F);
        rd(8'h4C, 8'h91);
        chk1("summary", 1'b1, host_err_summary);
        thr(2'h0, 8'hFF);
        rd(8'h4C, 8'hC1);
        sleep_state = 2'h2;
        thr(2'h2, 8'h00);
        rd(8'h4C, 8'h00);
        finish_test;
    end
endmodule // testbench
bind hesb_top hesb_monitor u_hesb_monitor (.clk, .rst_b, .reg_addr,
    .reg_rd_en, .reg_rdata, .sleep_state, .diode_sleep_mask,
    .volt_out_of_window, .diode_fault, .fuse_input_eight,
    .legacy_vid_mode, .cpu1_vcore_mismatch, .host_err_summary);
